// >>> adc_port_asserts.sv
// concurrent checks on the serial command port pins
// bound to every instance of the port, all on mclk
`timescale 1ns/1ps
`default_nettype none
module adc_port_asserts
  import adc_port_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_TCLK
) (
  // system and core
  input wire logic mclk,
  input wire logic nrst,
  input wire logic result_strobe,
  input wire logic next_result_soon,
  input wire logic continuous_mode,
  input wire logic ctl_command_strobe,
  input wire logic [7:0] timeout_setting,
  // link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic shared_out_ready_pin_o,
  input wire logic shared_out_ready_pin_oe,
  input wire logic result_ready_pin
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_quiet; cs_n [*4] |-> !shared_out_ready_pin_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("shared pin driven while free");
  property p_init;
    $rose(nrst) |-> result_ready_pin && timeout_setting == REG_RESET_VALUE;
  endproperty
  a_init: assert property (p_init) else $error("bad state after reset");
  property p_fall; result_strobe |-> ##[1:3] !result_ready_pin; endproperty
  a_fall: assert property (p_fall) else $error("ready did not fall");
  property p_shared;
    $fell(result_ready_pin) && !cs_n && shared_out_ready_pin_oe |-> !shared_out_ready_pin_o;
  endproperty
  a_shared: assert property (p_shared) else $error("shared pin not low with ready");
  property p_pulse; next_result_soon && !result_ready_pin |-> ##[1:3] result_ready_pin; endproperty
  a_pulse: assert property (p_pulse) else $error("ready did not pulse");
  property p_hold;
    (!next_result_soon && cs_n) [*4] ##0 !result_ready_pin |=> !result_ready_pin;
  endproperty
  a_hold: assert property (p_hold) else $error("unread ready rose");
  property p_rise;
    $rose(sclk) && !cs_n && continuous_mode && !result_ready_pin |-> ##[1:6] result_ready_pin;
  endproperty
  a_rise: assert property (p_rise) else $error("ready not cleared by sclk");
  property p_gap; ctl_command_strobe |=> !ctl_command_strobe [*8]; endproperty
  a_gap: assert property (p_gap) else $error("command strobes too close");
endmodule
bind adc_serial_command_port adc_port_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (
  .mclk(mclk), .nrst(nrst), .result_strobe(result_strobe),
  .next_result_soon(next_result_soon), .continuous_mode(continuous_mode),
  .ctl_command_strobe(ctl_command_strobe), .timeout_setting(timeout_setting),
  .sclk(sclk), .cs_n(cs_n), .shared_out_ready_pin_o(shared_out_ready_pin_o),
  .shared_out_ready_pin_oe(shared_out_ready_pin_oe), .result_ready_pin(result_ready_pin));
`default_nettype wire

// >>> adc_port_pkg.sv
// constants shared by the serial command port of the converter
// assumes a 100 MHz system clock driving the converter-side logic
package adc_port_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // device clock periods before the next ready fall when the ready pin pulses high
  localparam int unsigned READY_PULSE_TCLK = 24;
  // timeout length in device clock periods
  localparam int unsigned TIMEOUT_TCLK = 32768;
  localparam int unsigned RESULT_BITS = 16;
  localparam int unsigned NUM_REGS = 18;
  localparam logic [15:0] CODE_POS_FULL = 16'h7fff;
  localparam logic [15:0] CODE_NEG_FULL = 16'h8000;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam logic [4:0] SYSCTL_ADDR = 5'h09;
  localparam int unsigned SYSCTL_TIMEOUT_BIT = 1;
  localparam logic [7:0] OP_IDLE = 8'h00;
  localparam logic [6:0] OP_WAKE = 7'h01;
  localparam logic [6:0] OP_SLEEP = 7'h02;
  localparam logic [6:0] OP_RESET = 7'h03;
  localparam logic [6:0] OP_START = 7'h04;
  localparam logic [6:0] OP_STOP = 7'h05;
  localparam logic [6:0] OP_RDATA = 7'h09;
  localparam logic [7:0] OP_SYS_OFS = 8'h16;
  localparam logic [7:0] OP_SYS_GAIN = 8'h17;
  localparam logic [7:0] OP_SELF_OFS = 8'h19;
  localparam logic [2:0] OP_REGISTER_READ_COMMAND_TOP = 3'h1;
  localparam logic [2:0] OP_REGISTER_WRITE_COMMAND_TOP = 3'h2;
  localparam logic [2:0] OP_COUNT_TOP = 3'h0;
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0, CMD_WAKE = 3'h1, CMD_SLEEP = 3'h2, CMD_RESET = 3'h3,
    CMD_START = 3'h4, CMD_STOP = 3'h5, CMD_CAL = 3'h6
  } ctl_cmd_t;
  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000, ST_COUNT = 3'b001, ST_XFER = 3'b011, ST_RDATA = 3'b010
  } port_state_t;
endpackage

// >>> adc_serial_command_port.sv
// serial command port: spi mode 1 slave, shared data-out/ready and ready pins
// assumes sclk is a link clock port (idle low); conversion core is outside,
// on mclk, and hands over results with a one-cycle strobe
//
// Overview of operation
// - select high resets port, tristates shared pin
// - conversions continue regardless of select
// - ready pin reports status regardless of select
// - sample on falling sclk, shift on rising
// - shared pin falls with ready pin
// - ready high after power-on until result
// - ready rises on first rising sclk in continuous mode
// - unread ready pulses high 24 clocks early
// - new result overwrites unread old result
// - timeout resets port after 2^15 idle clocks
// - timeout active only when enable bit set
// - results are 16-bit two's complement
// - output codes saturate at full scale
// - decode control opcodes ignoring low bit
// - decode calibration and read-data opcodes
// - register read is two command bytes
// - register write: two bytes then data
// - no result load during register access
// - command finished or aborted by select
// - only spi mode 1 supported
// - command decoded on eighth falling edge
// - result msb on first rising edge
// - reads past last register give zero
`timescale 1ns/1ps
`default_nettype none
module adc_serial_command_port
  import adc_port_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_TCLK
) (
  // system side
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  // conversion core
  input wire logic result_strobe,
  input wire logic [17:0] raw_result,
  input wire logic next_result_soon,
  input wire logic continuous_mode,
  output logic [2:0] ctl_command,
  output logic ctl_command_strobe,
  output logic [7:0] timeout_setting,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic shared_out_ready_pin_o,
  output logic shared_out_ready_pin_oe,
  output logic result_ready_pin
);
  initial begin
    if (TIMEOUT_CYCLES < 2) $error("timeout too short");
  end

  localparam int unsigned CNT_W = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(TIMEOUT_CYCLES - 1);

  // select level synchronised into mclk
  logic cs_m1, cs_m2;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cs_m1 <= 1'b1;
      cs_m2 <= 1'b1;
    end else if (clk_en) begin
      cs_m1 <= cs_n;
      cs_m2 <= cs_m1;
    end
  end

  // saturate the wide core result into 16-bit two's complement
  function automatic logic [15:0] clip(input logic [17:0] v);
    if (!v[17] && v[16:15] != 2'b00) clip = CODE_POS_FULL;
    else if (v[17] && v[16:15] != 2'b11) clip = CODE_NEG_FULL;
    else clip = v[15:0];
  endfunction

  // register file on mclk
  logic [7:0] regs [NUM_REGS];
  // serial-domain write request, crossed by toggle
  logic wr_tog_s;
  logic [4:0] wr_addr_s;
  logic [7:0] wr_data_s;
  logic wr_t1, wr_t2, wr_t3;
  logic [4:0] wr_addr_m;
  logic [7:0] wr_data_m;
  // mclk-side command and activity events, toggles from sclk side
  logic cmd_tog_s, byte_tog_s, acc_tog_s;
  logic [2:0] cmd_code_s;
  logic c1, c2, c3, b1, b2, b3, r1, r2, r3;
  logic [2:0] cmd_code_m;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {wr_t1, wr_t2, wr_t3, c1, c2, c3, b1, b2, b3, r1, r2, r3} <= '0;
      wr_addr_m <= '0;
      wr_data_m <= '0;
      cmd_code_m <= '0;
    end else if (clk_en) begin
      wr_t1 <= wr_tog_s;
      wr_t2 <= wr_t1;
      wr_t3 <= wr_t2;
      c1 <= cmd_tog_s;
      c2 <= c1;
      c3 <= c2;
      b1 <= byte_tog_s;
      b2 <= b1;
      b3 <= b2;
      r1 <= acc_tog_s;
      r2 <= r1;
      r3 <= r2;
      // payload is stable long before the toggle arrives
      wr_addr_m <= wr_addr_s;
      wr_data_m <= wr_data_s;
      cmd_code_m <= cmd_code_s;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) regs[gi] <= REG_RESET_VALUE;
        else if (clk_en) begin
          if (c2 != c3 && cmd_code_m == CMD_RESET) regs[gi] <= REG_RESET_VALUE;
          else if (wr_t2 != wr_t3 && wr_addr_m == 5'(gi)) regs[gi] <= wr_data_m;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) timeout_setting <= REG_RESET_VALUE;
    else if (clk_en) timeout_setting <= regs[SYSCTL_ADDR];
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctl_command <= CMD_NONE;
      ctl_command_strobe <= 1'b0;
    end else if (clk_en) begin
      ctl_command_strobe <= (c2 != c3) && (cmd_code_m != CMD_NONE);
      if (c2 != c3) ctl_command <= cmd_code_m;
    end
  end

  // result holding: each new result overwrites the last
  logic [15:0] result;
  logic access_busy_m;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) result <= '0;
    else if (clk_en && result_strobe) result <= clip(raw_result);
  end

  // every rising sclk seen as activity toggle; the first after ready fall raises ready
  logic rise_tog_s;
  logic f1, f2, f3;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) {f1, f2, f3} <= '0;
    else if (clk_en) begin
      f1 <= rise_tog_s;
      f2 <= f1;
      f3 <= f2;
    end
  end

  // ready pin: high at power-on, falls on result, rises early or on sclk
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) result_ready_pin <= 1'b1;
    else if (clk_en) begin
      if (result_strobe) result_ready_pin <= 1'b0;
      else if (next_result_soon) result_ready_pin <= 1'b1;
      else if (continuous_mode && f2 != f3 && !cs_m2) result_ready_pin <= 1'b1;
    end
  end

  // access in progress flag, level from sclk side
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) access_busy_m <= 1'b0;
    else if (clk_en) access_busy_m <= (r2 != r3) ? ~access_busy_m : access_busy_m;
  end

  // result snapshot for shifting; blocked during register access
  logic [15:0] out_word_m;
  logic load_tog_m;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      out_word_m <= '0;
      load_tog_m <= 1'b0;
    end else if (clk_en && result_strobe && !access_busy_m) begin
      out_word_m <= clip(raw_result);
      load_tog_m <= ~load_tog_m;
    end
  end

  // timeout: counts idle mclk cycles, restarts on byte or select rise
  logic port_flush_m;
  logic [CNT_W-1:0] idle_cnt;
  logic cs_m3;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      idle_cnt <= '0;
      port_flush_m <= 1'b0;
      cs_m3 <= 1'b1;
    end else if (clk_en) begin
      cs_m3 <= cs_m2;
      port_flush_m <= 1'b0;
      if (!regs[SYSCTL_ADDR][SYSCTL_TIMEOUT_BIT] || (b2 != b3) || (cs_m2 && !cs_m3)) begin
        idle_cnt <= '0;
      end else if (idle_cnt == CNT_MAX) begin
        idle_cnt <= '0;
        port_flush_m <= 1'b1;
      end else begin
        idle_cnt <= idle_cnt + CNT_W'(1);
      end
    end
  end

  // ---------------- sclk domain ----------------
  // port reset while select high, on system reset or on a timeout pulse
  // the flush pulse comes from a flop, so it cannot glitch; the link clock may be idle
  wire port_rst_n = nrst & ~cs_n & ~port_flush_m;
  logic ld1, ld2, ld_seen, out_bit_s, out_sel_s;
  port_state_t state;
  logic [2:0] bit_cnt;
  logic [7:0] sh_in;
  logic [4:0] addr, count;
  logic is_write;
  logic [7:0] sh_out;
  logic [3:0] out_cnt;

  // samples on falling sclk
  always_ff @(negedge sclk or negedge port_rst_n) begin
    if (!port_rst_n) begin
      state <= ST_OPCODE;
      bit_cnt <= '0;
      sh_in <= '0;
      addr <= '0;
      count <= '0;
      is_write <= 1'b0;
      cmd_tog_s <= 1'b0;
      cmd_code_s <= CMD_NONE;
      byte_tog_s <= 1'b0;
      acc_tog_s <= 1'b0;
      wr_tog_s <= 1'b0;
      wr_addr_s <= '0;
      wr_data_s <= '0;
    end else begin
      sh_in <= {sh_in[6:0], din};
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        byte_tog_s <= ~byte_tog_s;
        case (state)
          ST_OPCODE: begin
            // full byte seen; control and read-data decode stand on bits 7..1 from the 7th edge, calibration on all 8 bits
            cmd_code_s <= CMD_NONE;
            if (sh_in[6:0] == {OP_IDLE[7:1]}) cmd_code_s <= CMD_NONE;
            else if (sh_in[6:0] == {1'b0, OP_WAKE[6:1]}) cmd_code_s <= CMD_WAKE;
            if (sh_in[6:0] == OP_WAKE) cmd_code_s <= CMD_WAKE;
            else if (sh_in[6:0] == OP_SLEEP) cmd_code_s <= CMD_SLEEP;
            else if (sh_in[6:0] == OP_RESET) cmd_code_s <= CMD_RESET;
            else if (sh_in[6:0] == OP_START) cmd_code_s <= CMD_START;
            else if (sh_in[6:0] == OP_STOP) cmd_code_s <= CMD_STOP;
            else if ({sh_in[6:0], din} == OP_SYS_OFS || {sh_in[6:0], din} == OP_SYS_GAIN
                     || {sh_in[6:0], din} == OP_SELF_OFS) cmd_code_s <= CMD_CAL;
            if (sh_in[6:0] == OP_RDATA) state <= ST_RDATA;
            else if (sh_in[6:4] == OP_REGISTER_READ_COMMAND_TOP || sh_in[6:4] == OP_REGISTER_WRITE_COMMAND_TOP) begin
              addr <= {sh_in[3:0], din};
              is_write <= (sh_in[6:4] == OP_REGISTER_WRITE_COMMAND_TOP);
              state <= ST_COUNT;
              acc_tog_s <= ~acc_tog_s;
            end
            cmd_tog_s <= ~cmd_tog_s;
          end
          ST_COUNT: begin
            if (sh_in[6:4] == OP_COUNT_TOP) count <= {sh_in[3:0], din};
            state <= ST_XFER;
          end
          ST_XFER: begin
            if (is_write && addr < 5'(NUM_REGS)) begin
              wr_addr_s <= addr;
              wr_data_s <= {sh_in[6:0], din};
              wr_tog_s <= ~wr_tog_s;
            end
            addr <= addr + 5'h1;
            count <= count - 5'h1;
            if (count == 5'h0) begin
              state <= ST_OPCODE;
              acc_tog_s <= ~acc_tog_s;
            end
          end
          // out_cnt wraps to zero once all 16 result bits have gone out
          ST_RDATA: if (out_cnt == 4'h0) state <= ST_OPCODE;
          default: state <= ST_OPCODE;
        endcase
      end
    end
  end

  // shifts out on rising sclk
  always_ff @(posedge sclk or negedge port_rst_n) begin
    if (!port_rst_n) begin
      {ld1, ld2, ld_seen} <= '0;
      sh_out <= '0;
      out_cnt <= '0;
      out_bit_s <= 1'b1;
      out_sel_s <= 1'b0;
      rise_tog_s <= 1'b0;
    end else begin
      ld1 <= load_tog_m;
      ld2 <= ld1;
      ld_seen <= ld2;
      rise_tog_s <= ~rise_tog_s;
      if (state == ST_RDATA && out_cnt == 4'h0) begin
        out_bit_s <= out_word_m[15];
        out_sel_s <= 1'b1;
        sh_out <= out_word_m[7:0];
        out_cnt <= 4'h1;
      end else if (state == ST_RDATA) begin
        out_bit_s <= (out_cnt < 4'h8) ? out_word_m[4'd15 - out_cnt] : sh_out[7];
        out_sel_s <= 1'b1;
        if (out_cnt >= 4'h8) sh_out <= {sh_out[6:0], 1'b0};
        out_cnt <= out_cnt + 4'h1;
      end else if (state == ST_XFER && !is_write) begin
        // past the last register the port returns zero
        out_bit_s <= (addr < 5'(NUM_REGS)) ? regs[addr][3'd7 - bit_cnt] : 1'b0;
        out_sel_s <= 1'b1;
        out_cnt <= '0;
      end else begin
        out_cnt <= '0;
        out_sel_s <= 1'b0;
      end
    end
  end

  // link bit and its select crossed into mclk; the pin flop sits on mclk so that
  // it can fall with the ready pin while the link clock stands still
  logic ob1, ob2, os1, os2;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {ob1, ob2, os1, os2} <= '0;
      shared_out_ready_pin_o <= 1'b1;
    end else if (clk_en) begin
      ob1 <= out_bit_s;
      ob2 <= ob1;
      os1 <= out_sel_s;
      os2 <= os1;
      if (os2) shared_out_ready_pin_o <= ob2;
      else if (result_strobe) shared_out_ready_pin_o <= 1'b0;
      else shared_out_ready_pin_o <= result_ready_pin;
    end
  end

  // shared pin enable follows select alone; the ready pin does not change it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) shared_out_ready_pin_oe <= 1'b0;
    else if (clk_en) shared_out_ready_pin_oe <= ~cs_m2;
  end
endmodule
`default_nettype wire

// >>> adc_serial_command_port_tb.sv
// self-checking bench for the serial command port
// host model drives the link, bench drives the converter side on mclk
`timescale 1ns/1ps
`default_nettype none
module adc_serial_command_port_tb;
  import adc_port_pkg::*;
  logic mclk = 1'h0, nrst = 1'h0, strobe = 1'h0, soon = 1'h0;
  logic en = 1'h1, cont = 1'h1;
  logic [17:0] raw = 18'h0;
  logic [2:0] cmd;
  logic cmd_stb, pin_o, pin_oe, rdy, sclk, cs_n, din;
  logic [7:0] tset;
  logic [15:0] rx;
  int n_errors = 0, checks = 0;
  // released pin shows the inverse, never a stale value
  wire dout = pin_oe ? pin_o : !pin_o;
  always #5 mclk = ~mclk;
  adc_serial_command_port #(.TIMEOUT_CYCLES(64)) dut (
    .mclk(mclk), .nrst(nrst), .clk_en(en), .result_strobe(strobe), .raw_result(raw),
    .next_result_soon(soon), .continuous_mode(cont), .ctl_command(cmd),
    .ctl_command_strobe(cmd_stb), .timeout_setting(tset), .sclk(sclk), .cs_n(cs_n),
    .din(din), .shared_out_ready_pin_o(pin_o), .shared_out_ready_pin_oe(pin_oe),
    .result_ready_pin(rdy));
  spi_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic post(input logic [17:0] v);
    @(posedge mclk);
    raw <= v;
    strobe <= 1'h1;
    @(posedge mclk);
    strobe <= 1'h0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] op);
    host.select(1'h1);
    host.shift(8, {8'h0, op}, rx);
    host.shift(16, 16'h0, rx);
    host.select(1'h0);
  endtask
  task automatic t_power_on;
    chk("ready", 16'h1, {15'h0, rdy});
    chk("oe", 16'h0, {15'h0, pin_oe});
    chk("timeout setting", 16'h0, {8'h0, tset});
  endtask
  task automatic t_ready_free;
    post(18'h00111);
    chk("ready free", 16'h0, {15'h0, rdy});
    chk("oe free", 16'h0, {15'h0, pin_oe});
    @(posedge mclk);
    soon <= 1'h1;
    @(posedge mclk);
    soon <= 1'h0;
    repeat (4) @(posedge mclk);
    chk("ready pulse", 16'h1, {15'h0, rdy});
    post(18'h00222);
    rd(8'h13);
    chk("newest result", 16'h0222, rx);
  endtask
  task automatic t_read_codes;
    logic [17:0] vals[4] = '{18'h01234, 18'h1ffff, 18'h20000, 18'h3fffe};
    logic [15:0] exps[4] = '{16'h1234, 16'h7fff, 16'h8000, 16'hfffe};
    for (int i = 0; i < 4; i++) begin
      host.select(1'h1);
      post(vals[i]);
      chk("shared low", 16'h0, {15'h0, pin_o});
      host.shift(8, 16'h0012, rx);
      chk("ready after sclk", 16'h1, {15'h0, rdy});
      host.shift(16, 16'h0, rx);
      host.select(1'h0);
      chk("code", exps[i], rx);
    end
  endtask
  task automatic wait_stb(input logic [2:0] exp);
    int k = 0;
    // step past the strobe of the previous command
    @(negedge mclk);
    while (cmd_stb !== 1'h1 && k < 200) begin
      @(negedge mclk);
      k++;
    end
    chk("strobe", 16'h1, {15'h0, cmd_stb});
    chk("command", {13'h0, exp}, {13'h0, cmd});
  endtask
  task automatic t_commands;
    logic [7:0] ops[8] = '{8'h02, 8'h05, 8'h06, 8'h09, 8'h0b, 8'h16, 8'h17, 8'h19};
    logic [2:0] exp[8] = '{CMD_WAKE, CMD_SLEEP, CMD_RESET, CMD_START, CMD_STOP,
      CMD_CAL, CMD_CAL, CMD_CAL};
    host.select(1'h1);
    for (int i = 0; i < 8; i++) begin
      fork
        host.shift(8, {8'h0, ops[i]}, rx);
        wait_stb(exp[i]);
      join
    end
    host.select(1'h0);
  endtask
  task automatic t_registers;
    host.select(1'h1);
    host.shift(16, 16'h4900, rx);
    host.shift(8, 16'h0002, rx);
    host.shift(16, 16'h5100, rx);
    host.shift(8, 16'h00a5, rx);
    // the write crosses into mclk before the setting copy updates
    repeat (6) @(posedge mclk);
    chk("timeout setting", 16'h0002, {8'h0, tset});
    host.shift(16, 16'h3101, rx);
    host.shift(16, 16'h0, rx);
    chk("read past end", 16'ha500, rx);
    host.shift(16, 16'h2900, rx);
    host.shift(8, 16'h0, rx);
    host.select(1'h0);
    chk("read back", 16'h0002, rx);
  endtask
  task automatic t_recovery;
    post(18'h00345);
    host.select(1'h1);
    host.shift(4, 16'h000f, rx);
    // past the 64-cycle limit set at the instance
    repeat (100) @(posedge mclk);
    host.shift(8, 16'h0012, rx);
    host.shift(16, 16'h0, rx);
    chk("after timeout", 16'h0345, rx);
    host.shift(4, 16'h000f, rx);
    host.select(1'h0);
    rd(8'h12);
    chk("after abort", 16'h0345, rx);
  endtask
  // whole run needs well under 100 us
  initial begin
    #500000;
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1'h1;
    repeat (3) @(posedge mclk);
    t_power_on();
    t_ready_free();
    t_read_codes();
    t_commands();
    t_registers();
    t_recovery();
    end_sim();
  end
endmodule
`default_nettype wire

// >>> spi_host_model.sv
// host side model: spi mode 1 master on the link
// bench calls select and shift; the link clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // link
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    din = 1'h0;
  end
  task automatic select(input logic on);
    #30;
    cs_n = !on;
    #30;
  endtask
  // 24 ns half periods make the 48 ns link clock; data read late in the low phase
  task automatic shift(input int n, input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'h1;
      din = tx[i];
      #24;
      sclk = 1'h0;
      #23;
      rx = {rx[14:0], dout};
      #1;
    end
    din = 1'h0;
  endtask
endmodule
`default_nettype wire
